// ---- logic/uart_pkg.sv ----
// constants for the serial port data path and its register map
// assumes one 25 MHz clock and a synchronous receive pin
package uart_pkg;
  localparam logic [31:0] BASE_ADDR = 32'h07E2_0100;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_RX_STAT = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  localparam logic [7:0] OFS_UNUSED_IR = 8'h20;
  localparam logic [7:0] OFS_BAUD_INT = 8'h24;
  localparam logic [7:0] OFS_BAUD_FRAC = 8'h28;
  localparam logic [7:0] OFS_LINE_CTRL = 8'h2C;
  localparam logic [7:0] OFS_CONTROL = 8'h30;
  localparam logic [7:0] OFS_IRQ_LEVEL = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
  localparam logic [7:0] OFS_RAW_IRQ = 8'h3C;
  localparam logic [7:0] OFS_MASKED_IRQ = 8'h40;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h44;
  localparam logic [7:0] OFS_DMA_CTRL = 8'h48;
  localparam logic [7:0] OFS_TEST_CTRL = 8'h80;
  localparam logic [7:0] OFS_TEST_IN = 8'h84;
  localparam logic [7:0] OFS_TEST_OUT = 8'h88;
  localparam logic [7:0] OFS_TEST_DATA = 8'h8C;
  // data port fields
  localparam int DP_FE = 8;
  localparam int DP_PE = 9;
  localparam int DP_BE = 10;
  localparam int DP_OE = 11;
  // receive status fields
  localparam int RS_OE = 3;
  // line control fields
  localparam int LC_BRK = 0;
  localparam int LC_PEN = 1;
  localparam int LC_EPS = 2;
  localparam int LC_STP2 = 3;
  localparam int LC_FEN = 4;
  localparam int LC_WLEN = 5;
  localparam int LC_SPS = 7;
  // control fields
  localparam int CR_EN = 0;
  localparam int CR_TXE = 8;
  localparam int CR_RXE = 9;
  // reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0300;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [15:0] BAUD_INT_RESET = 16'h0000;
  localparam logic [5:0] BAUD_FRAC_RESET = 6'h00;
  localparam logic [3:0] RX_STAT_RESET = 4'h0;
  // timing: ticks per bit and the mid-bit tick
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [2:0] WLEN_BASE = 3'h4;
  localparam int TX_DEPTH = 16;
  localparam int RX_DEPTH = 16;
  localparam int CHAR_W = 8;
  localparam int RX_W = 12;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;
endpackage

// ---- logic/uart_queue.sv ----
// queue used for the transmit and receive paths
// assumes DEPTH is a power of two; one_deep turns it into a holding register
`timescale 1ns/1ns
module uart_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic one_deep,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = DEPTH[AW:0];
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_push;
  logic do_pop;

  assign empty = (count_reg == '0);
  assign full = one_deep ? !empty : (count_reg == DEPTH_CNT);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign rdata = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ---- logic/uart_data_rx_status.sv ----
// serial port data path, receive error status and register map
// assumes a bus slave port with setup/access phases, synchronous pins
// Overview of operation
// - registers decode at base 0x7E20100, one 32-bit word each
// - offsets: data 0x0, status 0x4, flags 0x18, baud, line, control
// - queues on: data port write pushes the character to transmit queue
// - queues off: write lands in one transmit holding location
// - write starts transmission: start, data, optional parity, stop
// - each received character is stored with four error bits, 12 wide
// - queues off: received word sits in one receive holding location
// - data port: char 7:0, framing 8, parity 9, break 10, overrun 11
// - overrun sets when receive queue full, clears when word is stored
// - break is a receive input low for a whole frame
// - break loads one zero character, then waits for idle and start
// - queued errors travel with the character at the queue head
// - parity error when received parity mismatches even and stick select
// - framing error when the stop bit is not 1
// - status bits 2:0 are framing, parity, break of last read, bit 3 overrun
// - status overrun bit sets at once when an overrun happens
// - queue enable 0 gives one-entry holding, 1 gives full queues
// - stick parity sends and checks not even_parity_sel
`timescale 1ns/1ns
module uart_data_rx_status #(
  parameter logic [31:0] BASE = uart_pkg::BASE_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd
);
  import uart_pkg::*;

  logic [15:0] baud_int_reg;
  logic [5:0] baud_frac_reg;
  logic [7:0] line_ctrl_reg;
  logic [15:0] control_reg;
  logic [3:0] rx_stat_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic txd_reg;
  logic overrun_pending_reg;
  logic [15:0] baud_cnt_reg;
  logic [5:0] frac_acc_reg;
  logic tick_reg;
  logic [6:0] frac_sum;
  tx_state_t tx_state_reg;
  logic [3:0] tx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_xor_reg;
  logic tx_line_reg;
  rx_state_t rx_state_reg;
  logic [3:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_xor_reg;
  logic rx_one_reg;
  logic rx_par_bad_reg;
  logic rx_wait_high_reg;
  logic rx_push_reg;
  logic [10:0] rx_word_reg;
  logic access;
  logic base_ok;
  logic mapped;
  logic wr_en;
  logic rd_en;
  logic [7:0] ofs;
  logic queue_enable;
  logic [2:0] last_bit;
  logic tx_go;
  logic rx_go;
  logic tx_push;
  logic tx_pop;
  logic tx_empty;
  logic tx_full;
  logic [CHAR_W-1:0] tx_rdata;
  logic rx_pop;
  logic rx_empty;
  logic rx_full;
  logic [RX_W-1:0] rx_rdata;
  logic [RX_W-1:0] rx_wdata;
  logic overrun_event;
  logic rx_stored;
  logic [31:0] rd_mux;

  function automatic logic parity_bit(input logic x, input logic even_parity_sel,
                                      input logic stick_parity_sel);
    if (stick_parity_sel) begin
      parity_bit = !even_parity_sel;
    end else begin
      parity_bit = even_parity_sel ? x : !x;
    end
  endfunction

  assign ofs = paddr[7:0];
  assign access = psel && penable && !pready_reg;
  assign base_ok = (paddr[31:8] == BASE[31:8]) &&
    (paddr[1:0] == 2'b00);
  assign mapped = base_ok && (ofs == OFS_DATA || ofs == OFS_RX_STAT ||
    ofs == OFS_FLAG || ofs == OFS_UNUSED_IR || ofs == OFS_BAUD_INT ||
    ofs == OFS_BAUD_FRAC || ofs == OFS_LINE_CTRL || ofs == OFS_CONTROL ||
    ofs == OFS_IRQ_LEVEL || ofs == OFS_IRQ_MASK || ofs == OFS_RAW_IRQ ||
    ofs == OFS_MASKED_IRQ || ofs == OFS_IRQ_CLEAR || ofs == OFS_DMA_CTRL ||
    ofs == OFS_TEST_CTRL || ofs == OFS_TEST_IN || ofs == OFS_TEST_OUT ||
    ofs == OFS_TEST_DATA);
  assign wr_en = access && pwrite && mapped;
  assign rd_en = access && !pwrite && mapped;
  assign queue_enable = line_ctrl_reg[LC_FEN];
  assign last_bit = {1'b0, line_ctrl_reg[LC_WLEN+1:LC_WLEN]} + WLEN_BASE;
  assign tx_go = control_reg[CR_EN] && control_reg[CR_TXE];
  assign rx_go = control_reg[CR_EN] && control_reg[CR_RXE];
  assign tx_push = wr_en && ofs == OFS_DATA;
  assign tx_pop = tx_state_reg == TX_IDLE && tx_go && !tx_empty;
  assign rx_pop = rd_en && ofs == OFS_DATA && !rx_empty;
  assign overrun_event = rx_push_reg && rx_full;
  assign rx_stored = rx_push_reg && !rx_full;
  assign rx_wdata = {overrun_pending_reg, rx_word_reg};
  assign frac_sum = {1'b0, frac_acc_reg} + {1'b0, baud_frac_reg};

  uart_queue #(.WIDTH(CHAR_W), .DEPTH(TX_DEPTH)) u_tx_queue (
    .clk(clk),
    .rst_n(rst_n),
    .one_deep(!queue_enable),
    .push(tx_push),
    .wdata(pwdata[7:0]),
    .pop(tx_pop),
    .rdata(tx_rdata),
    .empty(tx_empty),
    .full(tx_full)
  );

  uart_queue #(.WIDTH(RX_W), .DEPTH(RX_DEPTH)) u_rx_queue (
    .clk(clk),
    .rst_n(rst_n),
    .one_deep(!queue_enable),
    .push(rx_push_reg),
    .wdata(rx_wdata),
    .pop(rx_pop),
    .rdata(rx_rdata),
    .empty(rx_empty),
    .full(rx_full)
  );

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ofs)
      OFS_DATA: rd_mux = rx_empty ? 32'h0000_0000 :
        {20'h00000, rx_rdata};
      OFS_RX_STAT: rd_mux = {28'h0000000, rx_stat_reg};
      OFS_FLAG: rd_mux = {24'h000000, tx_empty, rx_full, tx_full, rx_empty,
        !tx_empty || tx_state_reg != TX_IDLE, 2'b00, !cts_n};
      OFS_BAUD_INT: rd_mux = {16'h0000, baud_int_reg};
      OFS_BAUD_FRAC: rd_mux = {26'h0000000, baud_frac_reg};
      OFS_LINE_CTRL: rd_mux = {24'h000000, line_ctrl_reg};
      OFS_CONTROL: rd_mux = {16'h0000, control_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus answer one cycle after the access phase starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && !mapped;
      if (rd_en) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // writable configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_int_reg <= BAUD_INT_RESET;
      baud_frac_reg <= BAUD_FRAC_RESET;
      line_ctrl_reg <= LINE_CTRL_RESET;
      control_reg <= CONTROL_RESET;
    end else if (wr_en) begin
      if (ofs == OFS_BAUD_INT) begin
        baud_int_reg <= pwdata[15:0];
      end
      if (ofs == OFS_BAUD_FRAC) begin
        baud_frac_reg <= pwdata[5:0];
      end
      if (ofs == OFS_LINE_CTRL) begin
        line_ctrl_reg <= pwdata[7:0];
      end
      if (ofs == OFS_CONTROL) begin
        control_reg <= pwdata[15:0];
      end
    end
  end

  // receive status: read loads, write clears, overrun set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_stat_reg <= RX_STAT_RESET;
    end else begin
      if (wr_en && ofs == OFS_RX_STAT) begin
        rx_stat_reg[2:0] <= 3'h0;
      end else if (rx_pop) begin
        rx_stat_reg[2:0] <= rx_rdata[DP_BE:DP_FE];
      end
      if (overrun_event) begin
        rx_stat_reg[RS_OE] <= 1'b1;
      end else if (wr_en && ofs == OFS_RX_STAT) begin
        rx_stat_reg[RS_OE] <= 1'b0;
      end
    end
  end

  // overrun carried into the next stored word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_pending_reg <= 1'b0;
    end else if (overrun_event) begin
      overrun_pending_reg <= 1'b1;
    end else if (rx_stored) begin
      overrun_pending_reg <= 1'b0;
    end
  end

  // sixteen ticks per bit from integer and fractional divisor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_reg <= 16'h0000;
      frac_acc_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else if (baud_int_reg == 16'h0000) begin
      tick_reg <= 1'b0;
    end else if (baud_cnt_reg == 16'h0000) begin
      tick_reg <= 1'b1;
      frac_acc_reg <= frac_sum[5:0];
      baud_cnt_reg <= baud_int_reg - 16'h0001 + {15'h0000, frac_sum[6]};
    end else begin
      tick_reg <= 1'b0;
      baud_cnt_reg <= baud_cnt_reg - 16'h0001;
    end
  end

  // transmit engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_xor_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_state_reg <= TX_START;
            tx_shift_reg <= tx_rdata;
            tx_xor_reg <= 1'b0;
            tx_cnt_reg <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_line_reg <= 1'b0;
          end
        end
        TX_START: begin
          if (tick_reg) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == TICK_LAST) begin
              tx_state_reg <= TX_DATA;
              tx_line_reg <= tx_shift_reg[0];
            end
          end
        end
        TX_DATA: begin
          if (tick_reg) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == TICK_LAST) begin
              tx_xor_reg <= tx_xor_reg ^ tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg != last_bit) begin
                tx_line_reg <= tx_shift_reg[1];
              end else if (line_ctrl_reg[LC_PEN]) begin
                tx_state_reg <= TX_PAR;
                tx_line_reg <= parity_bit(tx_xor_reg ^ tx_shift_reg[0],
                  line_ctrl_reg[LC_EPS], line_ctrl_reg[LC_SPS]);
              end else begin
                tx_state_reg <= TX_STOP;
                tx_bit_reg <= 3'h0;
                tx_line_reg <= 1'b1;
              end
            end
          end
        end
        TX_PAR: begin
          if (tick_reg) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == TICK_LAST) begin
              tx_state_reg <= TX_STOP;
              tx_bit_reg <= 3'h0;
              tx_line_reg <= 1'b1;
            end
          end
        end
        TX_STOP: begin
          if (tick_reg) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == TICK_LAST) begin
              tx_bit_reg <= 3'h1;
              if (tx_bit_reg != 3'h0 || !line_ctrl_reg[LC_STP2]) begin
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // line output, held low while a break is being sent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_reg <= 1'b1;
    end else begin
      txd_reg <= tx_line_reg && !line_ctrl_reg[LC_BRK];
    end
  end

  // receive engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_xor_reg <= 1'b0;
      rx_one_reg <= 1'b0;
      rx_par_bad_reg <= 1'b0;
      rx_wait_high_reg <= 1'b0;
      rx_push_reg <= 1'b0;
      rx_word_reg <= 11'h000;
    end else begin
      rx_push_reg <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (rxd) begin
            rx_wait_high_reg <= 1'b0;
          end else if (rx_go && !rx_wait_high_reg) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg <= 4'h0;
          end
        end
        RX_START: begin
          if (tick_reg) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == TICK_MID) begin
              rx_cnt_reg <= 4'h0;
              rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
              rx_bit_reg <= 3'h0;
              rx_shift_reg <= 8'h00;
              rx_xor_reg <= 1'b0;
              rx_one_reg <= 1'b0;
              rx_par_bad_reg <= 1'b0;
            end
          end
        end
        RX_DATA: begin
          if (tick_reg) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == TICK_LAST) begin
              rx_shift_reg[rx_bit_reg] <= rxd;
              rx_xor_reg <= rx_xor_reg ^ rxd;
              rx_one_reg <= rx_one_reg || rxd;
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == last_bit) begin
                rx_state_reg <= line_ctrl_reg[LC_PEN] ? RX_PAR : RX_STOP;
              end
            end
          end
        end
        RX_PAR: begin
          if (tick_reg) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == TICK_LAST) begin
              rx_par_bad_reg <= rxd != parity_bit(rx_xor_reg,
                line_ctrl_reg[LC_EPS], line_ctrl_reg[LC_SPS]);
              rx_one_reg <= rx_one_reg || rxd;
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (tick_reg) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == TICK_LAST) begin
              rx_state_reg <= RX_IDLE;
              rx_push_reg <= 1'b1;
              if (!rxd && !rx_one_reg) begin
                rx_word_reg <= {1'b1, 2'b00, 8'h00};
                rx_wait_high_reg <= 1'b1;
              end else begin
                rx_word_reg <= {1'b0, rx_par_bad_reg, !rxd,
                  rx_shift_reg};
              end
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd = txd_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_access;
    psel && penable && !pready_reg;
  endsequence
  sequence s_rx_read;
    rx_pop ##1 pready_reg;
  endsequence

  property p_base_miss;
    s_access and (paddr[31:8] != BASE[31:8]) |=> pready && pslverr;
  endproperty
  a_base_miss: assert property (p_base_miss)
    else $error("foreign base answered without error");

  property p_decode;
    s_access and mapped |=> pready && !pslverr;
  endproperty
  a_decode: assert property (p_decode)
    else $error("mapped offset answered with error");

  property p_tx_push;
    tx_push && tx_empty |=> !tx_empty || $past(tx_pop);
  endproperty
  a_tx_push: assert property (p_tx_push)
    else $error("data port write did not reach transmit queue");

  property p_char_mode;
    !queue_enable && tx_push && tx_empty |=> tx_full && tx_rdata == $past(pwdata[7:0]);
  endproperty
  a_char_mode: assert property (p_char_mode)
    else $error("holding location not single entry");

  property p_start_bit;
    tx_pop |=> !tx_line_reg && tx_state_reg == TX_START;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("transmission did not open with start bit");

  property p_overrun;
    overrun_event |=> rx_stat_reg[RS_OE] && overrun_pending_reg;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged at once");

  property p_overrun_clear;
    rx_stored |=> !overrun_pending_reg;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("overrun not cleared after storing");

  property p_break_zero;
    rx_push_reg && rx_word_reg[DP_BE] |-> rx_word_reg[7:0] == 8'h00
      && rx_wait_high_reg;
  endproperty
  a_break_zero: assert property (p_break_zero)
    else $error("break did not load a zero character");

  property p_break_hold;
    rx_wait_high_reg && !rxd |=> rx_state_reg == RX_IDLE;
  endproperty
  a_break_hold: assert property (p_break_hold)
    else $error("new character started before line went high");

  property p_status_load;
    s_rx_read |-> rx_stat_reg[2:0] == $past(rx_rdata[DP_BE:DP_FE]);
  endproperty
  a_status_load: assert property (p_status_load)
    else $error("status bits not those of the character read");

  property p_stat_clear;
    wr_en && ofs == OFS_RX_STAT && !overrun_event |=> rx_stat_reg == 4'h0;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status write did not clear");
endmodule

// ---- test/serial_peer.sv ----
// serial peer model: drives the receive line, captures transmit frames
// assumes 16 clocks per bit (baud divisor 1) and 8n1 on transmit
`timescale 1ns/1ns
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  logic [8:0] got;
  int cnt = 0;
  initial rxd = 1'b1;
  // frame bits lsb first, 16 clocks each, then idle mark
  task automatic send(input logic [15:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      rxd = v[k];
      repeat (15) @(negedge clk);
    end
    @(negedge clk);
    rxd = 1'b1;
    repeat (40) @(negedge clk);
  endtask
  // mid-bit sampling, stop bit lands in got[8]
  always begin
    @(negedge txd);
    repeat (8) @(negedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(negedge clk);
      got[i] = txd;
    end
    cnt++;
  end
endmodule

// ---- test/uart_data_rx_status_tb.sv ----
// self-checking bench for the serial port data path and status
// assumes the peer model on the serial pins, baud divisor 1
`timescale 1ns/1ns
module uart_data_rx_status_tb;
  import uart_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, cts_n;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, rxd, txd, err;
  int error_cnt = 0;
  int tests_run = 0;
  int t;
  logic [31:0] seed = 32'd30;
  logic [7:0] d, d2;
  logic [7:0] lcs [4] = '{8'h76, 8'h72, 8'hF2, 8'hF6};
  uart_data_rx_status i_uart_data_rx_status (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd));
  serial_peer i_serial_peer (.clk(clk), .txd(txd), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // expected parity bit for a line control setting
  function automatic logic epar(input logic [7:0] v, input logic [7:0] lc);
    if (lc[7]) return ~lc[2];
    return lc[2] ? ^v : ~^v;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  // setup, access, hold until the answer has been sampled
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] wd);
    int n;
    @(negedge clk);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = w;
    paddr = a;
    pwdata = wd;
    @(negedge clk);
    penable = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("FAIL %0t no bus answer", $time);
    end
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask
  task automatic wr(input logic [7:0] o, input logic [31:0] v);
    bus(1'b1, BASE_ADDR | {24'h0, o}, v);
  endtask
  task automatic rdc(input logic [7:0] o, input logic [31:0] e);
    bus(1'b0, BASE_ADDR | {24'h0, o}, 32'h0);
    chk(rd, e);
  endtask
  task automatic txw(input int k);
    int n;
    n = 0;
    while (i_serial_peer.cnt < t + k && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk({23'h0, i_serial_peer.got}, {24'h1, d});
  endtask
  task automatic rxf(input logic [7:0] v);
    i_serial_peer.send({6'h0, 1'b1, v, 1'b0}, 10);
  endtask
  task summarize;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize;
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cts_n = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    rdc(OFS_DATA, 32'h0);
    rdc(OFS_RX_STAT, 32'h0);
    rdc(OFS_CONTROL, {16'h0, CONTROL_RESET});
    rdc(OFS_FLAG, 32'h91);
    rdc(OFS_TEST_CTRL, 32'h0);
    bus(1'b0, BASE_ADDR | 32'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, BASE_ADDR ^ 32'h1000, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OFS_BAUD_INT, 32'h1);
    wr(OFS_CONTROL, 32'h301);
    wr(OFS_LINE_CTRL, 32'h70);
    rdc(OFS_LINE_CTRL, 32'h70);
    // two queued characters back to back
    d = xs();
    d2 = xs();
    t = i_serial_peer.cnt;
    wr(OFS_DATA, {24'h0, d});
    wr(OFS_DATA, {24'h0, d2});
    txw(1);
    d = d2;
    txw(2);
    repeat (3) begin
      d = xs();
      rxf(d);
      rdc(OFS_DATA, {24'h0, d});
    end
    // every parity mode, good then bad parity bit
    for (int m = 0; m < 4; m++) begin
      wr(OFS_LINE_CTRL, {24'h0, lcs[m]});
      for (int b = 0; b < 2; b++) begin
        d = xs();
        i_serial_peer.send({5'h0, 1'b1, epar(d, lcs[m]) ^ b[0], d, 1'b0}, 11);
        rdc(OFS_DATA, {22'h0, b[0], 1'b0, d});
        rdc(OFS_RX_STAT, {30'h0, b[0], 1'b0});
      end
    end
    // seven data bits, upper bit of the character reads zero
    wr(OFS_LINE_CTRL, 32'h50);
    d = xs() & 8'h7F;
    i_serial_peer.send({7'h0, 1'b1, d[6:0], 1'b0}, 9);
    rdc(OFS_DATA, {24'h0, d});
    wr(OFS_LINE_CTRL, 32'h70);
    d = xs() | 8'h01;
    i_serial_peer.send({6'h0, 1'b0, d, 1'b0}, 10);
    rdc(OFS_DATA, {24'h1, d});
    rdc(OFS_RX_STAT, 32'h1);
    i_serial_peer.send(16'h0, 14);
    rdc(OFS_DATA, 32'h400);
    rdc(OFS_FLAG, 32'h91);
    cts_n = 1'b1;
    rdc(OFS_FLAG, 32'h90);
    rdc(OFS_RX_STAT, 32'h4);
    wr(OFS_RX_STAT, 32'h0);
    rdc(OFS_RX_STAT, 32'h0);
    // character mode: second word overruns the holding location
    wr(OFS_LINE_CTRL, 32'h60);
    d = xs();
    rxf(d);
    rxf(xs());
    rdc(OFS_RX_STAT, 32'h8);
    rdc(OFS_DATA, {24'h0, d});
    d = xs();
    rxf(d);
    rdc(OFS_DATA, {20'h0, 4'h8, d});
    wr(OFS_RX_STAT, 32'h0);
    rdc(OFS_RX_STAT, 32'h0);
    d = xs();
    t = i_serial_peer.cnt;
    wr(OFS_DATA, {24'h0, d});
    txw(1);
    summarize;
  end
endmodule
